// ==== hdl/lddr_pkg.sv ====
package lddr_pkg;

  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned STATE_W   = 5;
  localparam int unsigned DUTY_W    = 16;
  localparam int unsigned DAC_W     = 12;
  localparam int unsigned BOOST_W   = 11;
  localparam int unsigned AUTO_W    = 16;
  localparam int unsigned VOUT_W    = 32;

  // Printed offsets are register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_LIVE_STATE  = 8'h14;
  localparam logic [ADDR_W-1:0] IDX_IN_DUTY     = 8'h16;
  localparam logic [ADDR_W-1:0] IDX_OUT_DUTY    = 8'h18;
  localparam logic [ADDR_W-1:0] IDX_SINK_CODE   = 8'h1A;
  localparam logic [ADDR_W-1:0] IDX_BOOST_CODE  = 8'h1C;
  localparam logic [ADDR_W-1:0] IDX_AUTODETECT  = 8'h1E;
  localparam logic [ADDR_W-1:0] IDX_BOOST_VOUT  = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_LIVE_STATE = 8'(IDX_LIVE_STATE * 4);
  localparam logic [ADDR_W-1:0] ADDR_IN_DUTY    = 8'(IDX_IN_DUTY * 4);
  localparam logic [ADDR_W-1:0] ADDR_OUT_DUTY   = 8'(IDX_OUT_DUTY * 4);
  localparam logic [ADDR_W-1:0] ADDR_SINK_CODE  = 8'(IDX_SINK_CODE * 4);
  localparam logic [ADDR_W-1:0] ADDR_BOOST_CODE = 8'(IDX_BOOST_CODE * 4);
  localparam logic [ADDR_W-1:0] ADDR_AUTODETECT = 8'(IDX_AUTODETECT * 4);
  localparam logic [ADDR_W-1:0] ADDR_BOOST_VOUT = 8'(IDX_BOOST_VOUT * 4);

  localparam logic [DATA_W-1:0] RESET_VAL = 32'h0000_0000;

  // Live state codes
  localparam logic [STATE_W-1:0] LS_DISABLED    = 5'h00;
  localparam logic [STATE_W-1:0] LS_REG_START   = 5'h01;
  localparam logic [STATE_W-1:0] LS_MEM_READ    = 5'h02;
  localparam logic [STATE_W-1:0] LS_STANDBY     = 5'h03;
  localparam logic [STATE_W-1:0] LS_CONV_FIRST  = 5'h04;
  localparam logic [STATE_W-1:0] LS_CONV_LAST   = 5'h0F;
  localparam logic [STATE_W-1:0] LS_NORMAL      = 5'h10;
  localparam logic [STATE_W-1:0] LS_SHUTDOWN    = 5'h11;
  localparam logic [STATE_W-1:0] LS_STATE_A     = 5'h12;
  localparam logic [STATE_W-1:0] LS_EVERY_FAIL  = 5'h13;

  // Boost output formula constants
  localparam longint unsigned REF_UV        = 1210000;
  localparam longint unsigned SINK_NA_X10   = 189;
  localparam longint unsigned SLOPE_DIV     = 10000;
  localparam int unsigned     R1_OHM_DEF    = 100000;
  localparam int unsigned     R2_OHM_DEF    = 10000;

  typedef struct packed {
    logic [STATE_W-1:0] live_state_field;
    logic [DUTY_W-1:0]  in_duty;
    logic [DUTY_W-1:0]  out_duty;
    logic [DAC_W-1:0]   sink_dac_code_field;
    logic [BOOST_W-1:0] boost_code_field;
    logic [AUTO_W-1:0]  autodetect;
  } lddr_diag_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } lddr_apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } lddr_apb_rsp_t;

  typedef enum logic [1:0] {
    AP_IDLE   = 2'b01,
    AP_ACCESS = 2'b10
  } lddr_apb_st_t;

  typedef enum logic [4:0] {
    CL_OFF     = 5'b00001,
    CL_STARTUP = 5'b00010,
    CL_RUN     = 5'b00100,
    CL_STOP    = 5'b01000,
    CL_FAULT   = 5'b10000
  } lddr_class_t;

endpackage

// ==== hdl/lddr_apb_slave.sv ====
`timescale 1ns/1ns
module lddr_apb_slave (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire lddr_pkg::lddr_apb_req_t req_i,
  input  wire logic [31:0]            rd_word_i,
  input  wire logic                   hit_i,
  output lddr_pkg::lddr_apb_rsp_t     rsp_o
);

  lddr_pkg::lddr_apb_st_t st_q;
  lddr_pkg::lddr_apb_st_t st_d;
  logic [31:0]            rdata_q;
  logic [31:0]            rdata_d;
  logic                   err_q;
  logic                   err_d;
  logic                   setup;

  assign setup = req_i.psel && !req_i.penable;

  always_comb begin
    st_d    = st_q;
    rdata_d = rdata_q;
    err_d   = err_q;
    case (st_q)
      lddr_pkg::AP_IDLE: begin
        if (setup) begin
          // Data is latched in setup so the access phase answers at once
          rdata_d = (hit_i && !req_i.pwrite) ? rd_word_i : lddr_pkg::RESET_VAL;
          err_d   = !hit_i;
          st_d    = lddr_pkg::AP_ACCESS;
        end
      end
      lddr_pkg::AP_ACCESS: begin
        if (!(req_i.psel && req_i.penable)) begin
          st_d = lddr_pkg::AP_IDLE;
        end else begin
          st_d = lddr_pkg::AP_IDLE;
        end
      end
      default: begin
        st_d = lddr_pkg::AP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q    <= lddr_pkg::AP_IDLE;
      rdata_q <= lddr_pkg::RESET_VAL;
      err_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  assign rsp_o.pready  = (st_q == lddr_pkg::AP_ACCESS) && req_i.psel && req_i.penable;
  assign rsp_o.pslverr = rsp_o.pready && err_q;
  assign rsp_o.prdata  = rdata_q;

endmodule

// ==== hdl/lddr_vout_calc.sv ====
`timescale 1ns/1ns
module lddr_vout_calc #(
  parameter int unsigned R1_OHM = lddr_pkg::R1_OHM_DEF,
  parameter int unsigned R2_OHM = lddr_pkg::R2_OHM_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [10:0] code_i,
  output logic [31:0]      vout_uv_o
);

  // Fixed part folds to a constant; only the slope term depends on the code
  localparam longint unsigned BASE_UV = lddr_pkg::REF_UV * (longint'(R1_OHM) + longint'(R2_OHM))
                                        / longint'(R2_OHM);
  localparam longint unsigned SLOPE_K = longint'(R1_OHM) * lddr_pkg::SINK_NA_X10;

  logic [47:0] prod;
  logic [47:0] sum;
  logic [31:0] vout_q;
  logic [31:0] vout_d;

  always_comb begin
    prod   = 48'(SLOPE_K) * {37'h0, code_i};
    sum    = 48'(BASE_UV) + prod / 48'(lddr_pkg::SLOPE_DIV);
    // Saturate rather than wrap for extreme resistor choices
    vout_d = (sum[47:32] != 16'h0000) ? 32'hFFFF_FFFF : sum[31:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vout_q <= lddr_pkg::RESET_VAL;
    end else begin
      vout_q <= vout_d;
    end
  end

  assign vout_uv_o = vout_q;

endmodule

// ==== hdl/lddr_diag_bank.sv ====
// Chosen here: the APB register port.
`timescale 1ns/1ns
module lddr_diag_bank #(
  parameter int unsigned R1_OHM = lddr_pkg::R1_OHM_DEF,
  parameter int unsigned R2_OHM = lddr_pkg::R2_OHM_DEF
) (
  input  wire logic                 SYS_CLK_I,
  input  wire logic                 RST_I,
  input  wire logic                 PSEL_I,
  input  wire logic                 PENABLE_I,
  input  wire logic                 PWRITE_I,
  input  wire logic [7:0]           PADDR_I,
  input  wire logic [31:0]          PWDATA_I,
  output logic [31:0]               PRDATA_O,
  output logic                      PREADY_O,
  output logic                      PSLVERR_O,
  input  wire lddr_pkg::lddr_diag_t DIAG_I,
  output lddr_pkg::lddr_class_t     STATE_CLASS_O,
  output logic [31:0]               VOUT_UV_O
);

  lddr_pkg::lddr_apb_req_t req;
  lddr_pkg::lddr_apb_rsp_t rsp;
  lddr_pkg::lddr_diag_t    diag_q;
  lddr_pkg::lddr_diag_t    diag_d;
  lddr_pkg::lddr_class_t   class_q;
  lddr_pkg::lddr_class_t   class_d;
  logic [31:0]             rd_word;
  logic                    hit;
  logic [31:0]             vout_uv;

  assign req.psel    = PSEL_I;
  assign req.penable = PENABLE_I;
  assign req.pwrite  = PWRITE_I;
  assign req.paddr   = PADDR_I;
  assign req.pwdata  = PWDATA_I;

  // Sampled copy of the live values; software has no write path into it
  always_comb begin
    diag_d = DIAG_I;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      diag_q <= '0;
    end else begin
      diag_q <= diag_d;
    end
  end

  // Coarse class of the live state for the rest of the chip
  always_comb begin
    class_d = lddr_pkg::CL_FAULT;
    case (diag_q.live_state_field)
      lddr_pkg::LS_DISABLED:   class_d = lddr_pkg::CL_OFF;
      lddr_pkg::LS_REG_START,
      lddr_pkg::LS_MEM_READ:   class_d = lddr_pkg::CL_STARTUP;
      lddr_pkg::LS_STANDBY:    class_d = lddr_pkg::CL_OFF;
      lddr_pkg::LS_NORMAL:     class_d = lddr_pkg::CL_RUN;
      lddr_pkg::LS_SHUTDOWN:   class_d = lddr_pkg::CL_STOP;
      lddr_pkg::LS_STATE_A,
      lddr_pkg::LS_EVERY_FAIL: class_d = lddr_pkg::CL_FAULT;
      default: begin
        // Codes above the last defined one are treated as a fault
        if (diag_q.live_state_field >= lddr_pkg::LS_CONV_FIRST &&
            diag_q.live_state_field <= lddr_pkg::LS_CONV_LAST) begin
          class_d = lddr_pkg::CL_STARTUP;
        end else begin
          class_d = lddr_pkg::CL_FAULT;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      class_q <= lddr_pkg::CL_OFF;
    end else begin
      class_q <= class_d;
    end
  end

  lddr_vout_calc #(
    .R1_OHM (R1_OHM),
    .R2_OHM (R2_OHM)
  ) u_vout (
    .clk_i     (SYS_CLK_I),
    .rst_i     (RST_I),
    .code_i    (diag_q.boost_code_field),
    .vout_uv_o (vout_uv)
  );

  // Read decode; writes reach no storage at all
  always_comb begin
    rd_word = lddr_pkg::RESET_VAL;
    hit     = 1'b1;
    case (PADDR_I)
      lddr_pkg::ADDR_LIVE_STATE: rd_word = {27'h0, diag_q.live_state_field};
      lddr_pkg::ADDR_IN_DUTY:    rd_word = {16'h0, diag_q.in_duty};
      lddr_pkg::ADDR_OUT_DUTY:   rd_word = {16'h0, diag_q.out_duty};
      lddr_pkg::ADDR_SINK_CODE:  rd_word = {20'h0, diag_q.sink_dac_code_field};
      lddr_pkg::ADDR_BOOST_CODE: rd_word = {21'h0, diag_q.boost_code_field};
      lddr_pkg::ADDR_AUTODETECT: rd_word = {16'h0, diag_q.autodetect};
      lddr_pkg::ADDR_BOOST_VOUT: rd_word = vout_uv;
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  lddr_apb_slave u_apb (
    .clk_i     (SYS_CLK_I),
    .rst_i     (RST_I),
    .req_i     (req),
    .rd_word_i (rd_word),
    .hit_i     (hit),
    .rsp_o     (rsp)
  );

  assign PRDATA_O      = rsp.prdata;
  assign PREADY_O      = rsp.pready;
  assign PSLVERR_O     = rsp.pslverr;
  assign STATE_CLASS_O = class_q;
  assign VOUT_UV_O     = vout_uv;

endmodule

// ==== tb/lddr_chk_asserts.sv ====
`timescale 1ns/1ns
module lddr_chk #(
  parameter int unsigned R1_OHM = 100000,
  parameter int unsigned R2_OHM = 10000
) (
  input wire logic                  SYS_CLK_I,
  input wire logic                  RST_I,
  input wire logic                  PSEL_I,
  input wire logic                  PENABLE_I,
  input wire logic                  PWRITE_I,
  input wire logic [7:0]            PADDR_I,
  input wire logic [31:0]           PRDATA_O,
  input wire logic                  PREADY_O,
  input wire logic                  PSLVERR_O,
  input wire lddr_pkg::lddr_diag_t  DIAG_I,
  input wire lddr_pkg::lddr_class_t STATE_CLASS_O,
  input wire logic [31:0]           VOUT_UV_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  // Reads within two edges of reset see a zeroed pipeline, so they are left out
  sequence s_rd(logic [7:0] a);
    PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == a && !$past(RST_I) && !$past(RST_I, 2);
  endsequence
  live_read_a: assert property (s_rd(8'h50) |->
    PRDATA_O == {27'h0, $past(DIAG_I.live_state_field, 2)}) else $error("live state");
  in_duty_a: assert property (s_rd(8'h58) |->
    PRDATA_O == {16'h0, $past(DIAG_I.in_duty, 2)}) else $error("input duty");
  out_duty_a: assert property (s_rd(8'h60) |->
    PRDATA_O == {16'h0, $past(DIAG_I.out_duty, 2)}) else $error("output duty");
  sink_code_a: assert property (s_rd(8'h68) |->
    PRDATA_O == {20'h0, $past(DIAG_I.sink_dac_code_field, 2)}) else $error("sink code");
  boost_code_a: assert property (s_rd(8'h70) |->
    PRDATA_O == {21'h0, $past(DIAG_I.boost_code_field, 2)}) else $error("boost code");
  boost_volt_a: assert property (!$past(RST_I) && !$past(RST_I, 2) |->
    VOUT_UV_O == 32'(64'd1210000 * (R1_OHM + R2_OHM) / R2_OHM
    + 64'(R1_OHM) * 189 * $past(DIAG_I.boost_code_field, 2) / 10000)) else $error("volts");
  write_okay_a: assert property (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 8'h50
    && !$past(RST_I) |-> PREADY_O && !PSLVERR_O && PRDATA_O == 32'h0) else $error("write");
  reset_clear_a: assert property ($fell(RST_I) |-> PRDATA_O == 32'h0
    && VOUT_UV_O == 32'h0 && STATE_CLASS_O == lddr_pkg::CL_OFF) else $error("reset");
endmodule
bind lddr_diag_bank lddr_chk #(.R1_OHM(R1_OHM), .R2_OHM(R2_OHM)) u_lddr_chk (
  .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .DIAG_I(DIAG_I), .STATE_CLASS_O(STATE_CLASS_O), .VOUT_UV_O(VOUT_UV_O));

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
  typedef struct packed {lddr_pkg::lddr_diag_t d; logic [31:0] v;} lddr_row_t;
  logic                  clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0, prdata, vout, rd;
  logic                  pready, pslverr, err;
  lddr_pkg::lddr_diag_t  diag = '0;
  lddr_pkg::lddr_class_t cls;
  int                    errors = 0, tests_run = 0;
  logic [7:0]            adr [6] = '{8'h50, 8'h58, 8'h60, 8'h68, 8'h70, 8'h78};
  lddr_row_t             rows [3] = '{
    '{{5'h13, 16'hFFFF, 16'h8001, 12'hFFF, 11'h7FF, 16'hA5A5}, 32'h0106_20CE},
    '{{5'h0A, 16'h1234, 16'hFEDC, 12'h5A5, 11'h555, 16'h5A5A}, 32'h00F2_75BA},
    '{{5'h00, 16'h0000, 16'h0000, 12'h000, 11'h000, 16'h0000}, 32'h00CB_1830}};

  always #10 clk = ~clk;

  lddr_diag_bank u_lddr_diag_bank (
    .SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .DIAG_I(diag), .STATE_CLASS_O(cls), .VOUT_UV_O(vout));

  function automatic logic [31:0] fld(lddr_pkg::lddr_diag_t d, int i);
    case (i)
      0: return {27'h0, d.live_state_field};
      1: return {16'h0, d.in_duty};
      2: return {16'h0, d.out_duty};
      3: return {20'h0, d.sink_dac_code_field};
      4: return {21'h0, d.boost_code_field};
      default: return {16'h0, d.autodetect};
    endcase
  endfunction

  // Coarse state class expected for each live state code
  function automatic lddr_pkg::lddr_class_t cls_of(int s);
    if (s == 0 || s == 3) return lddr_pkg::CL_OFF;
    if (s < 16) return lddr_pkg::CL_STARTUP;
    if (s == 16) return lddr_pkg::CL_RUN;
    if (s == 17) return lddr_pkg::CL_STOP;
    return lddr_pkg::CL_FAULT;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'hFFFF_FFFF;
    @(posedge clk);
    penable <= 1'b1;
    // Answer is taken at the completing edge, before that edge's updates land
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[r]) begin
      diag <= rows[r].d;
      for (int i = 0; i < 6; i++) begin
        apb(1'b0, adr[i]);
        `CHK("reg", fld(rows[r].d, i), rd)
      end
      `CHK("vout", rows[r].v, vout)
    end
    for (int s = 0; s < 20; s++) begin
      diag.live_state_field <= 5'(s);
      apb(1'b0, 8'h50);
      `CHK("state", {27'h0, 5'(s)}, rd)
      `CHK("class", cls_of(s), cls)
    end
    apb(1'b1, 8'h50);
    `CHK("write err", 1'b0, err)
    `CHK("write data", 32'h0, rd)
    apb(1'b0, 8'h50);
    `CHK("after write", {27'h0, diag.live_state_field}, rd)
    apb(1'b0, 8'h54);
    `CHK("unmapped", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    `CHK("rst data", 32'h0, prdata)
    `CHK("rst vout", 32'h0, vout)
    `CHK("rst class", lddr_pkg::CL_OFF, cls)
    apb(1'b0, 8'h50);
    `CHK("post rst", {27'h0, diag.live_state_field}, rd)
    `CHK("post rst class", lddr_pkg::CL_FAULT, cls)
    complete_run();
  end

  // Forty-two transfers of three cycles each fit well inside this span
  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule
